// ==== rtl/field_rev_defines.svh ====
// Functional notes
// - any assigned high input inverts select input three
// - low fault input debounced, per-terminal fault code
// - fault and alarm come from terminals only
// - low alarm input raises per-terminal alarm
// - all checkback inputs high before leaving waiting
// - direction low contactor one, high contactor two
// - reversal runs to end, then recheck direction
// - armature off, zero current, field inhibit, low field
// - delay, open contactor, fixed gap, close other
// - invert speed polarity unless back-emf source
// - release field inhibit, half field, armature enable
// - brake button held minimum time, contactor closed
// - reverse for braking only if not already braking
// - internal shutdown, wait slow and zero, inhibit pulses
// - hold shutdown until release then off and on
// - after release reverse back only on mismatch
// - field monitor wait at start, delayed fault running
// - all field monitor inputs high means field ok
`ifndef FIELD_REV_DEFINES_SVH
`define FIELD_REV_DEFINES_SVH

// register indices on the plain port
`define ADDR_MAP_LAST 4'h6
`define ADDR_DEB 4'h7
`define ADDR_CHG 4'h8
`define ADDR_SRC 4'h9
`define ADDR_WAIT 4'hA
`define ADDR_GRACE 4'hB
`define ADDR_STATUS 4'hC
`define ADDR_ISTS 4'hD
`define ADDR_IMASK 4'hE

// function map slots
`define MAP_POL 0
`define MAP_FLT 1
`define MAP_ALM 2
`define MAP_LC 3
`define MAP_DIR 4
`define MAP_BRK 5
`define MAP_FOK 6

// interrupt status bits
`define IRQ_FLT 0
`define IRQ_ALM 1
`define IRQ_FFLT 2
`define IRQ_REV 3
`define IRQ_BRK 4

// reset values and back-emf source code
`define RST_DEB 16'h000A
`define RST_CHG 12'h000
`define RST_SRC 2'h0
`define RST_WAIT 16'h01F4
`define RST_GRACE 16'h0000
`define SRC_EMF 2'h3

// timing
`define MCLK_HZ 32'h0098_9680
`define HZ_PER_KHZ 32'h0000_03E8
`define CONTACTOR_GAP_MS 17'h0_0064
`define BRAKE_HOLD_MS 17'h0_001E
`define FIELD_FAULT_MS 17'h0_01F4

`endif

// ==== rtl/field_rev_pkg.sv ====
package field_rev_pkg;
    typedef enum logic [5:0] {
        R_IDLE = 6'h01,
        R_ARM = 6'h02,
        R_FLD = 6'h04,
        R_DLY = 6'h08,
        R_OPEN = 6'h10,
        R_RISE = 6'h20
    } rev_state_t;

    typedef enum logic [5:0] {
        B_IDLE = 6'h01,
        B_STOP = 6'h02,
        B_HOLD = 6'h04,
        B_BACK = 6'h08,
        B_OFF = 6'h10,
        B_ON = 6'h20
    } brk_state_t;

    typedef struct packed {
        rev_state_t rs;
        brk_state_t bs;
        logic [15:0] div;
        logic tick;
        logic [15:0] rcnt;
        logic dir;
        logic c1;
        logic c2;
        logic fpi;
        logic arm_en;
        logic spinv;
        logic shut;
        logic apinh;
        logic sel3inv;
        logic lc_ok;
        logic fok;
        logic ffault;
        logic [5:0] flt;
        logic [5:0] alm;
        logic [6:0][5:0] map;
        logic [15:0] deb;
        logic [11:0] chg;
        logic [1:0] src;
        logic [15:0] wait_ms;
        logic [15:0] grace;
        logic [4:0] ists;
        logic [4:0] imask;
        logic [15:0] rdata;
    } core_t;

    typedef struct packed {
        logic [16:0] cnt;
        logic done;
    } hold_t;
endpackage

// ==== rtl/field_reversal_binary_inputs.sv ====
// Our own choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`include "field_rev_defines.svh"
module field_reversal_binary_inputs #(
    parameter int CYC_PER_MS = `MCLK_HZ / `HZ_PER_KHZ
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    output logic irq,
    input wire logic [5:0] term_in,
    input wire logic armature_current_zero,
    input wire logic field_below_min,
    input wire logic field_above_half,
    input wire logic speed_below_min,
    input wire logic speed_negative_raw,
    input wire logic line_contactor_closed,
    input wire logic switch_on_cmd,
    input wire logic field_wait_phase,
    input wire logic drive_running,
    output logic select3_invert,
    output logic [5:0] external_fault,
    output logic [5:0] external_alarm,
    output logic line_contactor_ok,
    output logic external_field_ok,
    output logic field_fault,
    output logic field_contactor_one_out,
    output logic field_contactor_two_out,
    output logic field_pulse_inhibit,
    output logic armature_enable,
    output logic speed_polarity_invert,
    output logic internal_shutdown,
    output logic armature_pulse_inhibit
);
    // refuse divider settings the tick logic cannot serve
    if (CYC_PER_MS < 2 || CYC_PER_MS > 65535) begin : g_chk
        $error("CYC_PER_MS out of range");
    end

    field_rev_pkg::core_t s_r;
    field_rev_pkg::core_t s_nxt;
    hold_if hi [8] ();
    logic [7:0] done;
    logic dir_in;
    logic btn;
    logic rev_go;
    logic brk_req;
    logic [4:0] iset;
    logic [4:0] iclr;

    // terminal decoding: any-high direction and brake button functions
    assign dir_in = |(term_in & s_r.map[`MAP_DIR]);
    assign btn = |(term_in & s_r.map[`MAP_BRK]);

    // one hold timer per fault terminal, brake button and field monitor
    for (genvar g = 0; g < 8; g++) begin : g_hold
        assign hi[g].tick = s_r.tick;
        if (g < 6) begin : g_flt
            assign hi[g].level = s_r.map[`MAP_FLT][g] & ~term_in[g];
            assign hi[g].limit = {1'b0, s_r.deb};
        end else if (g == 6) begin : g_brk
            assign hi[g].level = btn & line_contactor_closed;
            assign hi[g].limit = `BRAKE_HOLD_MS;
        end else begin : g_fok
            assign hi[g].level = (field_wait_phase | drive_running) & ~s_r.fok;
            assign hi[g].limit = field_wait_phase ? {1'b0, s_r.wait_ms}
                                                  : {1'b0, s_r.grace} + `FIELD_FAULT_MS;
        end
        assign done[g] = hi[g].done;
        hold_timer u_hold (
            .mclk(mclk),
            .resetn(resetn),
            .hi(hi[g])
        );
    end

    // next state of the whole block
    always_comb begin
        s_nxt = s_r;
        rev_go = 1'b0;
        brk_req = 1'b0;
        iset = 5'h00;
        iclr = 5'h00;
        s_nxt.rdata = 16'h0000;

        // millisecond tick divider
        s_nxt.tick = 1'b0;
        if (s_r.div == 16'(CYC_PER_MS - 1)) begin
            s_nxt.div = 16'h0000;
            s_nxt.tick = 1'b1;
        end else begin
            s_nxt.div = s_r.div + 16'h0001;
        end

        // register writes
        if (reg_wr) begin
            if (reg_addr <= `ADDR_MAP_LAST) begin
                s_nxt.map[reg_addr[2:0]] = reg_wdata[5:0];
            end
            case (reg_addr)
                `ADDR_DEB: s_nxt.deb = reg_wdata;
                `ADDR_CHG: s_nxt.chg = reg_wdata[11:0];
                `ADDR_SRC: s_nxt.src = reg_wdata[1:0];
                `ADDR_WAIT: s_nxt.wait_ms = reg_wdata;
                `ADDR_GRACE: s_nxt.grace = reg_wdata;
                `ADDR_ISTS: iclr = reg_wdata[4:0];
                `ADDR_IMASK: s_nxt.imask = reg_wdata[4:0];
                default: ;
            endcase
        end

        // sampled input functions
        s_nxt.sel3inv = |(term_in & s_r.map[`MAP_POL]);
        s_nxt.flt = done[5:0];
        s_nxt.alm = s_r.map[`MAP_ALM] & ~term_in;
        s_nxt.lc_ok = &(term_in | ~s_r.map[`MAP_LC]);
        s_nxt.fok = &(term_in | ~s_r.map[`MAP_FOK]);
        s_nxt.ffault = done[7];
        iset[`IRQ_FLT] = |(s_nxt.flt & ~s_r.flt);
        iset[`IRQ_ALM] = |(s_nxt.alm & ~s_r.alm);
        iset[`IRQ_FFLT] = s_nxt.ffault & ~s_r.ffault;

        // braking with field reversal
        case (s_r.bs)
            field_rev_pkg::B_IDLE: begin
                if (done[6]) begin
                    s_nxt.bs = field_rev_pkg::B_STOP;
                    s_nxt.shut = 1'b1;
                    brk_req = ~(speed_negative_raw ^ s_r.dir);
                end
            end
            field_rev_pkg::B_STOP: begin
                if (s_r.rs == field_rev_pkg::R_IDLE && speed_below_min && armature_current_zero) begin
                    s_nxt.apinh = 1'b1;
                    s_nxt.bs = field_rev_pkg::B_HOLD;
                end
            end
            field_rev_pkg::B_HOLD: begin
                if (!btn) begin
                    s_nxt.bs = field_rev_pkg::B_BACK;
                end
            end
            field_rev_pkg::B_BACK: begin
                if (s_r.rs == field_rev_pkg::R_IDLE) begin
                    if (dir_in != s_r.dir) begin
                        brk_req = 1'b1;
                    end else begin
                        s_nxt.bs = field_rev_pkg::B_OFF;
                    end
                end
            end
            field_rev_pkg::B_OFF: begin
                if (!switch_on_cmd) begin
                    s_nxt.bs = field_rev_pkg::B_ON;
                end
            end
            field_rev_pkg::B_ON: begin
                if (switch_on_cmd) begin
                    s_nxt.bs = field_rev_pkg::B_IDLE;
                    s_nxt.shut = 1'b0;
                    s_nxt.apinh = 1'b0;
                    iset[`IRQ_BRK] = 1'b1;
                end
            end
            default: s_nxt.bs = field_rev_pkg::B_IDLE;
        endcase

        // direction switch acts only outside a braking sequence
        rev_go = brk_req | (s_r.bs == field_rev_pkg::B_IDLE && !done[6] && dir_in != s_r.dir);

        // field reversal interlock sequence
        case (s_r.rs)
            field_rev_pkg::R_IDLE: begin
                if (rev_go) begin
                    s_nxt.rs = field_rev_pkg::R_ARM;
                    s_nxt.arm_en = 1'b0;
                end
            end
            field_rev_pkg::R_ARM: begin
                if (armature_current_zero) begin
                    s_nxt.rs = field_rev_pkg::R_FLD;
                    s_nxt.fpi = 1'b1;
                end
            end
            field_rev_pkg::R_FLD: begin
                if (field_below_min) begin
                    s_nxt.rs = field_rev_pkg::R_DLY;
                    s_nxt.rcnt = 16'h0000;
                end
            end
            field_rev_pkg::R_DLY: begin
                if (s_r.rcnt >= {4'h0, s_r.chg}) begin
                    s_nxt.rs = field_rev_pkg::R_OPEN;
                    s_nxt.c1 = 1'b0;
                    s_nxt.c2 = 1'b0;
                    s_nxt.rcnt = 16'h0000;
                end else if (s_r.tick) begin
                    s_nxt.rcnt = s_r.rcnt + 16'h0001;
                end
            end
            field_rev_pkg::R_OPEN: begin
                if ({1'b0, s_r.rcnt} >= `CONTACTOR_GAP_MS) begin
                    s_nxt.rs = field_rev_pkg::R_RISE;
                    s_nxt.dir = ~s_r.dir;
                    s_nxt.c1 = s_r.dir;
                    s_nxt.c2 = ~s_r.dir;
                    s_nxt.fpi = 1'b0;
                end else if (s_r.tick) begin
                    s_nxt.rcnt = s_r.rcnt + 16'h0001;
                end
            end
            field_rev_pkg::R_RISE: begin
                if (field_above_half) begin
                    s_nxt.rs = field_rev_pkg::R_IDLE;
                    s_nxt.arm_en = 1'b1;
                    iset[`IRQ_REV] = 1'b1;
                end
            end
            default: s_nxt.rs = field_rev_pkg::R_IDLE;
        endcase

        // speed polarity follows the selected field unless back-emf feedback
        s_nxt.spinv = s_nxt.dir && (s_nxt.src != `SRC_EMF);

        // sticky events, a new event beats a write-one clear
        s_nxt.ists = (s_r.ists & ~iclr) | iset;

        // register reads, data in the following cycle
        if (reg_rd) begin
            if (reg_addr <= `ADDR_MAP_LAST) begin
                s_nxt.rdata = {10'h000, s_r.map[reg_addr[2:0]]};
            end
            case (reg_addr)
                `ADDR_DEB: s_nxt.rdata = s_r.deb;
                `ADDR_CHG: s_nxt.rdata = {4'h0, s_r.chg};
                `ADDR_SRC: s_nxt.rdata = {14'h0000, s_r.src};
                `ADDR_WAIT: s_nxt.rdata = s_r.wait_ms;
                `ADDR_GRACE: s_nxt.rdata = s_r.grace;
                `ADDR_STATUS: s_nxt.rdata = {s_r.rs != field_rev_pkg::R_IDLE, s_r.bs != field_rev_pkg::B_IDLE,
                                             s_r.dir, s_r.c1, s_r.c2, s_r.fpi, s_r.arm_en, s_r.shut,
                                             s_r.apinh, s_r.lc_ok, s_r.fok, s_r.ffault, s_r.sel3inv, 3'h0};
                `ADDR_ISTS: s_nxt.rdata = {11'h000, s_r.ists};
                `ADDR_IMASK: s_nxt.rdata = {11'h000, s_r.imask};
                default: ;
            endcase
        end
    end

    // state register with constant reset values
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            s_r <= '0;
            s_r.rs <= field_rev_pkg::R_IDLE;
            s_r.bs <= field_rev_pkg::B_IDLE;
            s_r.c1 <= 1'b1;
            s_r.arm_en <= 1'b1;
            s_r.lc_ok <= 1'b1;
            s_r.fok <= 1'b1;
            s_r.deb <= `RST_DEB;
            s_r.chg <= `RST_CHG;
            s_r.src <= `RST_SRC;
            s_r.wait_ms <= `RST_WAIT;
            s_r.grace <= `RST_GRACE;
        end else begin
            s_r <= s_nxt;
        end
    end

    // outputs straight from the state register
    assign reg_rdata = s_r.rdata;
    assign irq = |(s_r.ists & s_r.imask);
    assign select3_invert = s_r.sel3inv;
    assign external_fault = s_r.flt;
    assign external_alarm = s_r.alm;
    assign line_contactor_ok = s_r.lc_ok;
    assign external_field_ok = s_r.fok;
    assign field_fault = s_r.ffault;
    assign field_contactor_one_out = s_r.c1;
    assign field_contactor_two_out = s_r.c2;
    assign field_pulse_inhibit = s_r.fpi;
    assign armature_enable = s_r.arm_en;
    assign speed_polarity_invert = s_r.spinv;
    assign internal_shutdown = s_r.shut;
    assign armature_pulse_inhibit = s_r.apinh;
endmodule

// ==== rtl/hold_if.sv ====
`timescale 1ns/1ps
interface hold_if;
    logic tick;
    logic level;
    logic [16:0] limit;
    logic done;
    modport ctl (output tick, output level, output limit, input done);
    modport tmr (input tick, input level, input limit, output done);
endinterface

// ==== rtl/hold_timer.sv ====
`timescale 1ns/1ps
module hold_timer (
    input wire logic mclk,
    input wire logic resetn,
    hold_if.tmr hi
);
    field_rev_pkg::hold_t s_r;
    field_rev_pkg::hold_t s_nxt;

    // count millisecond ticks while the level holds, done once past the limit
    always_comb begin
        s_nxt = s_r;
        if (!hi.level) begin
            s_nxt.cnt = 17'h0_0000;
            s_nxt.done = 1'b0;
        end else if (s_r.cnt > hi.limit) begin
            s_nxt.done = 1'b1;
        end else if (hi.tick) begin
            s_nxt.cnt = s_r.cnt + 17'h0_0001;
        end
    end

    // state register
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign hi.done = s_r.done;
endmodule

// ==== sim/field_rev_monitor.sv ====
`timescale 1ns/1ps
module field_rev_monitor #(
    parameter int CYC_PER_MS = 4
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic armature_current_zero,
    input wire logic field_above_half,
    input wire logic speed_below_min,
    input wire logic line_contactor_closed,
    input wire logic switch_on_cmd,
    input wire logic field_contactor_one_out,
    input wire logic field_contactor_two_out,
    input wire logic field_pulse_inhibit,
    input wire logic armature_enable,
    input wire logic speed_polarity_invert,
    input wire logic internal_shutdown,
    input wire logic armature_pulse_inhibit
);
    logic [15:0] gap_r;
    // cycles spent with both field contactors open
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            gap_r <= 16'h0000;
        end else if (field_contactor_one_out || field_contactor_two_out) begin
            gap_r <= 16'h0000;
        end else if (gap_r != 16'hFFFF) begin
            gap_r <= gap_r + 16'h0001;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    AST_CONTACTOR_EXCL: assert property (!(field_contactor_one_out && field_contactor_two_out))
        else $error("both field contactors on");
    AST_CONTACTOR_GAP: assert property (($rose(field_contactor_one_out) || $rose(field_contactor_two_out))
        |-> gap_r >= 16'(99 * CYC_PER_MS)) else $error("changeover gap too short");
    AST_OPEN_INHIBITED: assert property (($fell(field_contactor_one_out) || $fell(field_contactor_two_out))
        |-> field_pulse_inhibit && !armature_enable) else $error("contactor opened with field firing");
    AST_FPI_AFTER_ARM: assert property ($rose(field_pulse_inhibit)
        |-> !armature_enable && $past(armature_current_zero)) else $error("field inhibit before zero current");
    AST_FPI_ARM_OFF: assert property (field_pulse_inhibit |-> !armature_enable)
        else $error("armature enabled with field inhibited");
    AST_ARM_RESTORE: assert property ($rose(armature_enable)
        |-> $past(field_above_half) && !field_pulse_inhibit) else $error("armature enabled before field up");
    AST_FPI_RELEASE: assert property ($fell(field_pulse_inhibit)
        |-> field_contactor_one_out != field_contactor_two_out) else $error("field released without contactor");
    AST_SPINV_AT_SWAP: assert property ($changed(speed_polarity_invert)
        |-> $rose(field_contactor_one_out) || $rose(field_contactor_two_out)) else $error("polarity off swap");
    AST_APINH_CAUSE: assert property ($rose(armature_pulse_inhibit)
        |-> internal_shutdown && $past(speed_below_min) && $past(armature_current_zero))
        else $error("pulse inhibit without stop");
    AST_SHUT_CAUSE: assert property ($rose(internal_shutdown) |-> $past(line_contactor_closed))
        else $error("shutdown without line contactor");
    AST_SHUT_RELEASE: assert property ($fell(internal_shutdown) |-> $past(switch_on_cmd))
        else $error("shutdown cleared without switch-on");
    // main scenarios reached
    cover property ($rose(field_contactor_two_out));
    cover property ($rose(armature_pulse_inhibit));
    cover property ($fell(internal_shutdown));
endmodule

bind field_reversal_binary_inputs field_rev_monitor #(.CYC_PER_MS(CYC_PER_MS)) u_field_rev_monitor (
    .mclk, .resetn, .armature_current_zero, .field_above_half, .speed_below_min, .line_contactor_closed,
    .switch_on_cmd, .field_contactor_one_out, .field_contactor_two_out, .field_pulse_inhibit,
    .armature_enable, .speed_polarity_invert, .internal_shutdown, .armature_pulse_inhibit);

// ==== sim/field_rev_partner.sv ====
`timescale 1ns/1ps
module field_rev_partner (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic field_contactor_one_out,
    input wire logic field_contactor_two_out,
    input wire logic field_pulse_inhibit,
    input wire logic armature_enable,
    input wire logic internal_shutdown,
    output logic armature_current_zero,
    output logic field_below_min,
    output logic field_above_half,
    output logic speed_below_min
);
    logic [4:0] fld_r;
    logic [3:0] arm_r;
    logic [4:0] spd_r;
    // field, armature and speed settle gradually so every wait lasts several cycles
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            fld_r <= 5'h14;
            arm_r <= 4'h0;
            spd_r <= 5'h14;
        end else begin
            if ((field_contactor_one_out ^ field_contactor_two_out) && !field_pulse_inhibit) begin
                fld_r <= (fld_r == 5'h14) ? fld_r : fld_r + 5'h01;
            end else begin
                fld_r <= (fld_r == 5'h00) ? fld_r : fld_r - 5'h01;
            end
            arm_r <= (armature_enable && !internal_shutdown) ? 4'h0 : ((arm_r == 4'hF) ? arm_r : arm_r + 4'h1);
            spd_r <= internal_shutdown ? ((spd_r == 5'h00) ? spd_r : spd_r - 5'h01) : 5'h14;
        end
    end
    // status levels seen by the block
    assign armature_current_zero = (arm_r >= 4'h6);
    assign field_below_min = (fld_r < 5'h03);
    assign field_above_half = (fld_r > 5'h0A);
    assign speed_below_min = (spd_r < 5'h03);
endmodule

// ==== sim/field_reversal_binary_inputs_tb.sv ====
`timescale 1ns/1ps
`include "field_rev_defines.svh"
module field_reversal_binary_inputs_tb;
    localparam int CPM = 4;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [5:0] term_in = 6'h0F;
    logic speed_negative_raw = 1'b0;
    logic line_contactor_closed = 1'b1;
    logic switch_on_cmd = 1'b1;
    logic field_wait_phase = 1'b0;
    logic drive_running = 1'b0;
    logic [15:0] reg_rdata;
    logic [5:0] external_fault, external_alarm;
    logic irq, select3_invert, line_contactor_ok, external_field_ok, field_fault, field_contactor_one_out;
    logic field_contactor_two_out, field_pulse_inhibit, armature_enable, speed_polarity_invert;
    logic internal_shutdown, armature_pulse_inhibit, armature_current_zero, field_below_min;
    logic field_above_half, speed_below_min;
    logic [7:0] obs;
    int failures = 0;
    int n_compared = 0;
    int cyc = 0;
    always #50 mclk = ~mclk;
    field_reversal_binary_inputs #(.CYC_PER_MS(CPM)) u_field_reversal_binary_inputs (
        .mclk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq, .term_in,
        .armature_current_zero, .field_below_min, .field_above_half, .speed_below_min, .speed_negative_raw,
        .line_contactor_closed, .switch_on_cmd, .field_wait_phase, .drive_running, .select3_invert,
        .external_fault, .external_alarm, .line_contactor_ok, .external_field_ok, .field_fault,
        .field_contactor_one_out, .field_contactor_two_out, .field_pulse_inhibit, .armature_enable,
        .speed_polarity_invert, .internal_shutdown, .armature_pulse_inhibit);
    field_rev_partner u_field_rev_partner (
        .mclk, .resetn, .field_contactor_one_out, .field_contactor_two_out, .field_pulse_inhibit,
        .armature_enable, .internal_shutdown, .armature_current_zero, .field_below_min, .field_above_half,
        .speed_below_min);
    // sequence outputs gathered for bounded waits
    assign obs = {field_fault, armature_pulse_inhibit, internal_shutdown, speed_polarity_invert,
                  armature_enable, field_pulse_inhibit, field_contactor_two_out, field_contactor_one_out};
    task automatic conclude;
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic tk(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
        @(posedge mclk);
    endtask
    // wait a bounded time for one sequence output to reach a level
    task automatic wt(input int b, input logic v, input string nm);
        int i;
        for (i = 0; i < 4000 && obs[b] !== v; i++) tk(1);
        chk(nm, 16'(v), 16'(obs[b]));
    endtask
    task automatic t_regs;
        logic [15:0] d;
        int i;
        rd(`ADDR_DEB, d);
        chk("deb_reset", `RST_DEB, d);
        rd(`ADDR_WAIT, d);
        chk("wait_reset", `RST_WAIT, d);
        rd(`ADDR_GRACE, d);
        chk("grace_reset", `RST_GRACE, d);
        rd(4'hF, d);
        chk("unmapped", 16'h0000, d);
        for (i = 0; i < 7; i++) wr(4'(i), 16'h0001 << ((i == 6) ? 3 : i));
        wr(`ADDR_DEB, 16'h0003);
        wr(`ADDR_CHG, 16'h0002);
        wr(`ADDR_IMASK, 16'h001F);
        rd(`ADDR_CHG, d);
        chk("chg_rw", 16'h0002, d);
        $display("test regs done");
    endtask
    task automatic t_inputs;
        tk(2);
        chk("sel3_high", 16'h0001, 16'(select3_invert));
        term_in <= 6'h0A;
        tk(2);
        chk("sel3_low", 16'h0000, 16'(select3_invert));
        chk("alarm", 16'h0004, 16'(external_alarm));
        wr(`ADDR_ISTS, 16'h001F);
        term_in <= 6'h08;
        tk(2 * CPM);
        chk("fault_early", 16'h0000, 16'(external_fault));
        tk(3 * CPM);
        chk("fault_set", 16'h0002, 16'(external_fault));
        chk("irq_set", 16'h0001, 16'(irq));
        wr(`ADDR_IMASK, 16'h0000);
        tk(2);
        chk("irq_masked", 16'h0000, 16'(irq));
        wr(`ADDR_ISTS, 16'h001F);
        wr(`ADDR_IMASK, 16'h001F);
        term_in <= 6'h07;
        drive_running <= 1'b1;
        tk(2);
        chk("irq_clear", 16'h0000, 16'(irq));
        chk("lc_low", 16'h0000, 16'(line_contactor_ok));
        chk("fok_low", 16'h0000, 16'(external_field_ok));
        tk(480 * CPM);
        chk("ffault_early", 16'h0000, 16'(field_fault));
        tk(30 * CPM);
        chk("ffault_set", 16'h0001, 16'(field_fault));
        drive_running <= 1'b0;
        wr(`ADDR_WAIT, 16'h0005);
        field_wait_phase <= 1'b1;
        tk(4 * CPM);
        chk("fwait_early", 16'h0000, 16'(field_fault));
        tk(4 * CPM);
        chk("fwait_set", 16'h0001, 16'(field_fault));
        term_in <= 6'h0F;
        field_wait_phase <= 1'b0;
        tk(2);
        wr(`ADDR_ISTS, 16'h001F);
        chk("lc_high", 16'h0001, 16'(line_contactor_ok));
        $display("test inputs done");
    endtask
    task automatic t_rev;
        logic [15:0] d;
        term_in <= 6'h1F;
        wt(3, 1'b0, "arm_drop");
        term_in <= 6'h0F;
        wt(2, 1'b1, "fpi_set");
        wt(0, 1'b0, "c1_open");
        wt(1, 1'b1, "c2_close");
        chk("spinv_neg", 16'h0001, 16'(speed_polarity_invert));
        wt(3, 1'b1, "arm_back");
        wt(0, 1'b1, "c1_again");
        chk("spinv_pos", 16'h0000, 16'(speed_polarity_invert));
        wt(3, 1'b1, "arm_again");
        rd(`ADDR_ISTS, d);
        chk("rev_irq", 16'h0008, d & 16'h0008);
        wr(`ADDR_SRC, {14'h0000, `SRC_EMF});
        term_in <= 6'h1F;
        wt(1, 1'b1, "c2_emf");
        chk("spinv_emf", 16'h0000, 16'(speed_polarity_invert));
        wt(3, 1'b1, "arm_emf");
        term_in <= 6'h0F;
        wt(0, 1'b1, "c1_home");
        chk("spinv_home", 16'h0000, 16'(speed_polarity_invert));
        wt(3, 1'b1, "arm_home");
        wr(`ADDR_SRC, 16'h0000);
        $display("test reversal done");
    endtask
    task automatic t_brake;
        term_in <= 6'h2F;
        tk(20 * CPM);
        term_in <= 6'h0F;
        tk(4);
        chk("short_press", 16'h0000, 16'(internal_shutdown));
        term_in <= 6'h2F;
        wt(5, 1'b1, "shut_on");
        wt(1, 1'b1, "brake_rev");
        wt(6, 1'b1, "apinh_on");
        tk(50);
        chk("shut_held", 16'h0001, 16'(internal_shutdown));
        term_in <= 6'h0F;
        wt(0, 1'b1, "rev_back");
        wt(3, 1'b1, "arm_after");
        chk("still_off", 16'h0001, 16'(internal_shutdown));
        switch_on_cmd <= 1'b0;
        tk(4);
        switch_on_cmd <= 1'b1;
        wt(5, 1'b0, "shut_clear");
        speed_negative_raw <= 1'b1;
        term_in <= 6'h2F;
        wt(6, 1'b1, "apinh_braking");
        chk("no_rev", 16'h0001, 16'(field_contactor_one_out));
        term_in <= 6'h0F;
        tk(20);
        chk("no_back", 16'h0001, 16'(field_contactor_one_out));
        switch_on_cmd <= 1'b0;
        tk(4);
        switch_on_cmd <= 1'b1;
        wt(5, 1'b0, "shut_clear2");
        speed_negative_raw <= 1'b0;
        $display("test braking done");
    endtask
    // cycle ceiling against a hung sequence
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 60000) begin
            failures++;
            $display("mismatch timeout expected finish seen hang");
            conclude();
        end
    end
    initial begin
        repeat (12) @(posedge mclk);
        resetn <= 1'b1;
        tk(1);
        t_regs();
        t_inputs();
        t_rev();
        t_brake();
        conclude();
    end
endmodule
